// File: rtl/spi_mode_serial_port.sv
`timescale 1ns/100ps
`default_nettype none

module spi_mode_serial_port
    import spi_port_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [5:0]   serialControl,
    input  wire logic         clockEdgeSel,
    input  wire logic [7:0]   portCDirection,
    input  wire logic [7:0]   portADirection,
    input  wire logic         timerPulse,
    input  wire logic         bufWrite,
    input  wire logic [7:0]   bufWrData,
    input  wire logic         bufRead,
    input  wire logic         collisionClear,
    input  wire logic         overflowClear,
    input  wire logic         intFlagClear,
    input  wire pins_in_type  pinIn,
    output pins_out_type      pinOut,
    output logic [7:0]        rdData,
    output logic              bufferFull,
    output logic              writeCollision,
    output logic              overflow,
    output logic              portIntFlag,
    output logic              wakeEvent,
    output logic              busy
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        master_state_type state;
        logic [5:0]       divCnt;
        logic [7:0]       shifter;
        logic             outBit;
        logic [2:0]       bitCnt;
        logic             sckS1;
        logic             sckS2;
        logic             sckPrev;
        logic             sdiS1;
        logic             sdiS2;
        logic             selS1;
        logic             selS2;
        logic             sckOut;
        logic             sckOe;
        logic             sdoOe;
        logic             busy;
        logic             mSample;
        logic             collision;
        logic             overflow;
        logic             full;
        logic             intFlag;
        logic             wake;
        logic [7:0]       xferBuf;
    } port_state_type;

    port_state_type q;
    port_state_type d;

    logic       enable;
    logic       idleLevel;
    logic [3:0] mode;
    logic       isMaster;
    logic       selUsed;
    logic       selected;
    logic       sdiBit;
    logic [5:0] halfTop;
    logic       halfTick;
    logic       mLead;
    logic       mTrail;
    logic       sLead;
    logic       sTrail;
    logic       lead;
    logic       trail;
    logic       sampleEv;
    logic       shiftEv;
    logic       lastBit;
    logic       complete;
    logic [7:0] rxByte;
    logic       fifoInReady;
    logic       fifoOutValid;
    logic [7:0] fifoOutData;
    logic       fifoOutReady;
    logic       inProgress;
    logic       writeOk;
    logic       writeBad;
    logic       drain;

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    assign enable    = serialControl[ENABLE_POS];
    assign idleLevel = serialControl[IDLE_POS];
    assign mode      = serialControl[MODE_MSB:0];
    assign isMaster  = (mode == MODE_MASTER_DIV4) || (mode == MODE_MASTER_DIV16)
                    || (mode == MODE_MASTER_DIV64) || (mode == MODE_MASTER_TMR);

    // A select pin turned into an output no longer qualifies the slave
    assign selUsed  = (mode == MODE_SLAVE_SEL)
                   && portADirection[DIR_SEL_POS];
    assign selected = !selUsed || !q.selS2;

    // An input pin turned into an output feeds zeros to the shifter
    assign sdiBit = portCDirection[DIR_SDI_POS] && q.sdiS2;

    // ----------------------------------------------------------------
    // Master bit clock
    // ----------------------------------------------------------------
    always_comb begin
        case (mode)
            MODE_MASTER_DIV16: halfTop = HALF_DIV16;
            MODE_MASTER_DIV64: halfTop = HALF_DIV64;
            default:           halfTop = HALF_DIV4;
        endcase
    end

    // Timer mode: each timer pulse is half a bit, so the bit rate is half
    assign halfTick = (mode == MODE_MASTER_TMR) ? timerPulse
                    : (q.divCnt == halfTop - 6'h01);

    assign mLead  = isMaster && (q.state == ST_WAIT) && halfTick;
    assign mTrail = isMaster && (q.state == ST_ACT) && halfTick;

    // ----------------------------------------------------------------
    // Slave clock edges, taken from the synchronised pin
    // ----------------------------------------------------------------
    assign sLead  = !isMaster && selected
                 && (q.sckS2 != idleLevel) && (q.sckPrev == idleLevel);
    assign sTrail = !isMaster && selected
                 && (q.sckS2 == idleLevel) && (q.sckPrev != idleLevel);

    assign lead  = enable && (mLead || sLead);
    assign trail = enable && (mTrail || sTrail);

    // Edge select: capture on one edge, present on the other
    // Master data in lags its own clock by the synchroniser, so it samples a cycle late
    assign sampleEv = isMaster ? q.mSample : (clockEdgeSel ? lead : trail);
    assign shiftEv  = clockEdgeSel ? trail : lead;

    assign lastBit  = (q.bitCnt == LAST_BIT);
    assign complete = sampleEv && lastBit;
    assign rxByte   = {q.shifter[6:0], sdiBit};

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // Up to two more received bytes wait here while the first sits unread
    assign fifoOutReady = !q.full || bufRead;
    assign drain        = fifoOutValid && fifoOutReady;

    two_entry_buffer #(
        .DATA_W   (BYTE_W)
    ) rxBuffer (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .clear    (!enable),
        .inValid  (complete),
        .inData   (rxByte),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (fifoOutReady)
    );

    // ----------------------------------------------------------------
    // Software write handling
    // ----------------------------------------------------------------
    assign inProgress = isMaster ? (q.state != ST_IDLE) : (q.bitCnt != 3'h0);
    // A master also refuses when no room is left for its answer byte
    assign writeBad = bufWrite && (inProgress || (isMaster && !fifoInReady));
    assign writeOk  = bufWrite && enable && !writeBad;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;

        // Pins cross into the core clock through two flip-flops
        d.sckS1   = pinIn.sck;
        d.sckS2   = q.sckS1;
        d.sckPrev = q.sckS2;
        d.sdiS1   = pinIn.serial_in_pin;
        d.sdiS2   = q.sdiS1;
        d.selS1   = pinIn.selN;
        d.selS2   = q.selS1;
        d.mSample = isMaster && (clockEdgeSel ? lead : trail);

        if (q.state == ST_IDLE || halfTick) begin
            d.divCnt = 6'h00;
        end else begin
            d.divCnt = q.divCnt + 6'h01;
        end

        // Shifter only loads from a buffer write or from the pin
        if (writeOk) begin
            d.shifter = bufWrData;
            d.outBit  = bufWrData[BYTE_W-1];
            if (isMaster) begin
                d.state  = ST_WAIT;
                d.divCnt = 6'h00;
            end
        end

        if (shiftEv) begin
            d.outBit = q.shifter[BYTE_W-1];
        end
        if (sampleEv) begin
            d.shifter = rxByte;
            d.bitCnt  = q.bitCnt + 3'h1;
        end

        case (q.state)
            ST_IDLE: begin
                d.sckOut = idleLevel;
            end
            ST_WAIT: begin
                if (mLead) begin
                    d.sckOut = !idleLevel;
                    d.state  = ST_ACT;
                end
            end
            ST_ACT: begin
                if (mTrail) begin
                    d.sckOut = idleLevel;
                    if (clockEdgeSel ? (q.bitCnt != 3'h0) : !lastBit) begin
                        d.state = ST_WAIT;
                    end else if (!portCDirection[DIR_SCK_POS]) begin
                        d.state = ST_IDLE;
                    end else begin
                        // Clock pin as input: keep running the internal clock, so the transfer only returns to idle when the port is disabled
                        d.state = ST_WAIT;
                    end
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // A deselected slave drops any partial byte
        if (!isMaster && !selected) begin
            d.bitCnt = 3'h0;
        end

        if (!enable) begin
            d.state  = ST_IDLE;
            d.bitCnt = 3'h0;
            d.sckOut = idleLevel;
        end

        d.busy  = enable && (isMaster ? (d.state != ST_IDLE) : (d.bitCnt != 3'h0));
        d.sckOe = enable && isMaster && !portCDirection[DIR_SCK_POS];
        d.sdoOe = enable && !portCDirection[DIR_SDO_POS]
               && (isMaster || selected);

        // Sticky flags: a set in the same cycle beats the clear
        if (collisionClear) begin
            d.collision = 1'b0;
        end
        if (writeBad) begin
            d.collision = 1'b1;
        end
        if (overflowClear) begin
            d.overflow = 1'b0;
        end
        // A slave cannot be held off, so a byte with no room is lost
        if (complete && !fifoInReady) begin
            d.overflow = 1'b1;
        end

        if (intFlagClear) begin
            d.intFlag = 1'b0;
        end
        d.wake = 1'b0;
        if (bufRead) begin
            d.full = 1'b0;
        end
        if (drain) begin
            d.xferBuf = fifoOutData;
            d.full    = 1'b1;
            d.intFlag = 1'b1;
            // Slave logic runs on the core clock, which stays up in sleep
            d.wake    = !isMaster;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q         <= '0;
            q.state   <= ST_IDLE;
            q.selS1   <= 1'b1;
            q.selS2   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pinOut.sckOut = q.sckOut;
    assign pinOut.sckOe  = q.sckOe;
    assign pinOut.sdoOut = q.outBit;
    assign pinOut.sdoOe  = q.sdoOe;
    assign rdData         = q.xferBuf;
    assign bufferFull     = q.full;
    assign writeCollision = q.collision;
    assign overflow       = q.overflow;
    assign portIntFlag    = q.intFlag;
    assign wakeEvent      = q.wake;
    assign busy           = q.busy;

endmodule

`default_nettype wire

// File: rtl/spi_port_pkg.sv
package spi_port_pkg;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int ENABLE_POS  = 5;
    localparam int IDLE_POS    = 4;
    localparam int MODE_MSB    = 3;
    localparam int DIR_SCK_POS = 3;
    localparam int DIR_SDI_POS = 4;
    localparam int DIR_SDO_POS = 5;
    localparam int DIR_SEL_POS = 5;
    localparam int BYTE_W      = 8;

    // ----------------------------------------------------------------
    // Mode encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
    localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MASTER_TMR   = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SEL    = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSEL  = 4'h5;

    // ----------------------------------------------------------------
    // Timing: bit period in core clocks, half period derived
    // ----------------------------------------------------------------
    localparam int BIT_DIV4  = 4;
    localparam int BIT_DIV16 = 16;
    localparam int BIT_DIV64 = 64;
    localparam logic [5:0] HALF_DIV4  = 6'(BIT_DIV4 / 2);
    localparam logic [5:0] HALF_DIV16 = 6'(BIT_DIV16 / 2);
    localparam logic [5:0] HALF_DIV64 = 6'(BIT_DIV64 / 2);
    localparam logic [2:0] LAST_BIT   = 3'h7;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACT  = 2'b11
    } master_state_type;

    typedef struct packed {
        logic sck;
        logic serial_in_pin;
        logic selN;
    } pins_in_type;

    typedef struct packed {
        logic sckOut;
        logic sckOe;
        logic sdoOut;
        logic sdoOe;
    } pins_out_type;

endpackage

// File: rtl/two_entry_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer
    import spi_port_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              clear,
    input  wire logic              inValid,
    input  wire logic [DATA_W-1:0] inData,
    output logic                   inReady,
    output logic                   outValid,
    output logic [DATA_W-1:0]      outData,
    input  wire logic              outReady
);

    typedef struct packed {
        logic              headValid;
        logic [DATA_W-1:0] head;
        logic              tailValid;
        logic [DATA_W-1:0] tail;
    } buf_state_type;

    buf_state_type q;
    buf_state_type d;
    logic          push;
    logic          pop;

    // Head is the read register, tail only fills when head is held
    assign inReady  = !q.tailValid;
    assign outValid = q.headValid;
    assign outData  = q.head;
    assign push     = inValid && !q.tailValid;
    assign pop      = q.headValid && outReady;

    always_comb begin
        d = q;
        if (pop) begin
            if (q.tailValid) begin
                d.head      = q.tail;
                d.tailValid = 1'b0;
                if (push) begin
                    d.tail      = inData;
                    d.tailValid = 1'b1;
                end
            end else begin
                d.head      = inData;
                d.headValid = push;
            end
        end else if (push) begin
            if (!q.headValid) begin
                d.head      = inData;
                d.headValid = 1'b1;
            end else begin
                d.tail      = inData;
                d.tailValid = 1'b1;
            end
        end
        if (clear) begin
            d.headValid = 1'b0;
            d.tailValid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// File: tb/spi_port_checker.sv
`timescale 1ns/100ps
`default_nettype none

module spi_port_checker
    import spi_port_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [5:0]   serialControl,
    input  wire logic         clockEdgeSel,
    input  wire logic [7:0]   portCDirection,
    input  wire logic [7:0]   portADirection,
    input  wire logic         timerPulse,
    input  wire logic         bufWrite,
    input  wire logic [7:0]   bufWrData,
    input  wire logic         bufRead,
    input  wire logic         collisionClear,
    input  wire logic         overflowClear,
    input  wire logic         intFlagClear,
    input  wire pins_in_type  pinIn,
    input  wire pins_out_type pinOut,
    input  wire logic [7:0]   rdData,
    input  wire logic         bufferFull,
    input  wire logic         writeCollision,
    input  wire logic         overflow,
    input  wire logic         portIntFlag,
    input  wire logic         wakeEvent,
    input  wire logic         busy
);
    logic en;
    logic isM;
    assign en = serialControl[ENABLE_POS];
    assign isM = en && serialControl[3:0] < MODE_SLAVE_SEL && !portCDirection[DIR_SCK_POS];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // Port behaviour
    // ----------------------------------------------------------------
    a_disable_release: assert property ((!en)[*2] |-> !pinOut.sckOe && !pinOut.sdoOe)
        else $error("pins driven while port disabled");
    a_sdo_override: assert property ((en && portCDirection[DIR_SDO_POS])[*2] |-> !pinOut.sdoOe)
        else $error("data out driven against its direction bit");
    a_master_clock: assert property (isM[*2] |-> pinOut.sckOe)
        else $error("master does not drive its clock");
    a_slave_clock: assert property ((en && serialControl[3:0] >= MODE_SLAVE_SEL)[*2] |-> !pinOut.sckOe)
        else $error("slave drives the clock pin");
    a_write_start: assert property (isM && bufWrite && !busy && !bufferFull |=> busy)
        else $error("master write did not start a transfer");
    a_byte_length: assert property ($rose(busy) && isM && serialControl[3:0] == MODE_MASTER_DIV4
        |-> busy[*8] ##24 busy ##1 !busy)
        else $error("fast master transfer length wrong");
    a_collision_set: assert property (en && bufWrite && busy |=> writeCollision)
        else $error("write during transfer not flagged");
    a_collision_hold: assert property (en && writeCollision && !collisionClear |=> writeCollision)
        else $error("collision flag dropped by itself");
    a_read_clears: assert property (bufRead && bufferFull |=> !bufferFull || $changed(rdData))
        else $error("buffer read did not clear full flag");
    a_full_flag: assert property ($rose(bufferFull) |-> portIntFlag)
        else $error("buffer full without interrupt flag");
    a_idle_level: assert property ((isM && !busy)[*4] |-> pinOut.sckOut == serialControl[IDLE_POS])
        else $error("idle clock level wrong");
    a_wake_pulse: assert property (wakeEvent |-> serialControl[3:0] >= MODE_SLAVE_SEL ##1 !wakeEvent)
        else $error("wake pulse outside slave mode or too long");
    a_deselect_quiet: assert property ((en && serialControl[3:0] == MODE_SLAVE_SEL && pinIn.selN
        && portADirection[DIR_SEL_POS])[*4] |-> !pinOut.sdoOe && !busy)
        else $error("deselected slave active");

    c_master_done: cover property (isM ##1 $fell(busy));
    c_collision: cover property ($rose(writeCollision));
    c_wake: cover property (wakeEvent);
    c_deselect: cover property (en && serialControl[3:0] == MODE_SLAVE_SEL && pinIn.selN);
endmodule

bind spi_mode_serial_port spi_port_checker chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .serialControl(serialControl),
    .clockEdgeSel(clockEdgeSel), .portCDirection(portCDirection),
    .portADirection(portADirection), .timerPulse(timerPulse), .bufWrite(bufWrite),
    .bufWrData(bufWrData), .bufRead(bufRead), .collisionClear(collisionClear),
    .overflowClear(overflowClear), .intFlagClear(intFlagClear), .pinIn(pinIn),
    .pinOut(pinOut), .rdData(rdData), .bufferFull(bufferFull),
    .writeCollision(writeCollision), .overflow(overflow), .portIntFlag(portIntFlag),
    .wakeEvent(wakeEvent), .busy(busy));

`default_nettype wire

// File: tb/spi_peer_model.sv
`timescale 1ns/100ps
`default_nettype none

module spi_peer_model (
    input  wire logic       ref_clk,
    input  wire logic       sck,
    input  wire logic       serial_out_pin,
    input  wire logic       idleLvl,
    input  wire logic       load,
    input  wire logic [7:0] loadData,
    output logic            serial_in_pin,
    output logic [7:0]      rxByte
);
    logic [7:0] txSr;

    always @(posedge ref_clk) begin
        if (load) begin
            txSr <= loadData;
        end
    end

    // Leading edge captures, trailing edge shifts; spent bits refill inverted
    // so a stale line never looks like valid data
    always @(sck) begin
        if (sck !== idleLvl) begin
            rxByte = {rxByte[6:0], serial_out_pin};
        end else begin
            txSr = {txSr[6:0], ~txSr[7]};
        end
    end

    assign serial_in_pin = txSr[7];
endmodule

`default_nettype wire

// File: tb/spi_mode_serial_port_test.sv
`timescale 1ns/100ps
`default_nettype none

module spi_mode_serial_port_test
    import spi_port_pkg::*;
;
    logic ref_clk, rst_b, clockEdgeSel, timerPulse, bufWrite, bufRead;
    logic collisionClear, overflowClear, intFlagClear;
    logic [5:0] serialControl;
    logic [7:0] portCDirection, portADirection, bufWrData, rdData, peerData, peerRx, q;
    pins_in_type pinIn;
    pins_out_type pinOut;
    logic bufferFull, writeCollision, overflow, portIntFlag, wakeEvent, busy;
    logic tbSck, tbSdi, tbSel, slaveTest, peerLoad, peerSdi;
    logic [1:0] tmrCnt;
    int fails, n_compared, wakes;

    assign pinIn.sck = pinOut.sckOe ? pinOut.sckOut : tbSck;
    assign pinIn.serial_in_pin = slaveTest ? tbSdi : peerSdi;
    assign pinIn.selN = tbSel;

    spi_mode_serial_port DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .serialControl(serialControl),
        .clockEdgeSel(clockEdgeSel), .portCDirection(portCDirection),
        .portADirection(portADirection), .timerPulse(timerPulse), .bufWrite(bufWrite),
        .bufWrData(bufWrData), .bufRead(bufRead), .collisionClear(collisionClear),
        .overflowClear(overflowClear), .intFlagClear(intFlagClear), .pinIn(pinIn),
        .pinOut(pinOut), .rdData(rdData), .bufferFull(bufferFull),
        .writeCollision(writeCollision), .overflow(overflow), .portIntFlag(portIntFlag),
        .wakeEvent(wakeEvent), .busy(busy));

    spi_peer_model peer (
        .ref_clk(ref_clk), .sck(pinIn.sck), .serial_out_pin(pinOut.sdoOut),
        .idleLvl(serialControl[IDLE_POS]), .load(peerLoad), .loadData(peerData),
        .serial_in_pin(peerSdi), .rxByte(peerRx));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Timer output every third cycle, so one timed bit is six cycles
    always @(posedge ref_clk) begin
        tmrCnt <= (tmrCnt == 2'h2) ? 2'h0 : tmrCnt + 2'h1;
        timerPulse <= (tmrCnt == 2'h2);
        if (wakeEvent === 1'b1) begin
            wakes <= wakes + 1;
        end
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic cfg(input logic [5:0] c);
        @(posedge ref_clk);
        serialControl <= {1'b0, c[4:0]};
        tbSck <= c[IDLE_POS];
        @(posedge ref_clk);
        serialControl <= c;
        tick(3);
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge ref_clk);
        bufWrite <= 1'b1;
        bufWrData <= d;
        @(posedge ref_clk);
        bufWrite <= 1'b0;
    endtask

    // Reads the buffer before any further write
    task automatic rdChk(input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        chk(16'(rdData), 16'(exp));
        @(posedge ref_clk);
        bufRead <= 1'b1;
        @(posedge ref_clk);
        bufRead <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic clr;
        @(posedge ref_clk);
        intFlagClear <= 1'b1;
        collisionClear <= 1'b1;
        @(posedge ref_clk);
        intFlagClear <= 1'b0;
        collisionClear <= 1'b0;
    endtask

    task automatic waitFlag;
        int n;
        n = 0;
        while (portIntFlag !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(16'(portIntFlag), 16'h1);
    endtask

    task automatic mxfer(input logic [3:0] m, input logic id, input logic [7:0] tx,
                         input logic [7:0] px);
        int len;
        len = 0;
        cfg({1'b1, id, m});
        @(posedge ref_clk);
        peerLoad <= 1'b1;
        peerData <= px;
        @(posedge ref_clk);
        peerLoad <= 1'b0;
        wr(tx);
        @(posedge ref_clk);
        #1;
        while (busy === 1'b1 && len < 2000) begin
            @(posedge ref_clk);
            #1;
            len++;
        end
        if (m != MODE_MASTER_TMR) begin
            chk(16'(len), 16'(8 * (BIT_DIV4 << (2 * m)) - 1));
        end
        waitFlag;
        chk(16'(peerRx), 16'(tx));
        chk(16'(pinOut.sckOut), 16'(id));
        chk(16'(bufferFull), 16'h1);
        rdChk(px);
        chk(16'(bufferFull), 16'h0);
        clr;
    endtask

    task automatic sbits(input logic [7:0] d, input int nb, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge ref_clk);
            tbSdi <= d[i];
            tick(5);
            tbSck <= 1'b1;
            r[i] = pinOut.sdoOut;
            tick(5);
            tbSck <= 1'b0;
        end
        tick(8);
        #1;
    endtask

    task automatic give_verdict;
        $display("TB: compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        fails++;
        give_verdict;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0; serialControl = 6'h00; clockEdgeSel = 1'b1; tmrCnt = 2'h0;
        portCDirection = 8'h10; portADirection = 8'h20; timerPulse = 1'b0;
        bufWrite = 1'b0; bufWrData = 8'h00; bufRead = 1'b0; collisionClear = 1'b0;
        overflowClear = 1'b0; intFlagClear = 1'b0; tbSck = 1'b0; tbSdi = 1'b0;
        tbSel = 1'b0; slaveTest = 1'b0; peerLoad = 1'b0; peerData = 8'h00;
        wakes = 0; fails = 0; n_compared = 0;
        tick(6);
        rst_b <= 1'b1;
        tick(3);
        #1;
        chk(16'({busy, bufferFull, writeCollision, portIntFlag, pinOut}), 16'h0);
        for (int m = 0; m < 4; m++) begin
            mxfer(4'(m), m[0], 8'(8'ha5 ^ m), 8'(8'h3c + m));
        end
        $display("test master rates done");
        mxfer(MODE_MASTER_DIV4, 1'b0, 8'h11, 8'h77);
        cfg({1'b1, 1'b0, MODE_MASTER_DIV4});
        wr(8'h11);
        wr(8'hee);
        waitFlag;
        chk(16'(peerRx), 16'h0011);
        chk(16'(writeCollision), 16'h1);
        rdChk(8'h88);
        clr;
        @(posedge ref_clk);
        #1;
        chk(16'(writeCollision), 16'h0);
        @(posedge ref_clk);
        portCDirection <= 8'h30;
        tick(3);
        #1;
        chk(16'(pinOut.sdoOe), 16'h0);
        @(posedge ref_clk);
        portCDirection <= 8'h10;
        serialControl <= 6'h00;
        tick(3);
        #1;
        chk(16'({pinOut.sckOe, pinOut.sdoOe}), 16'h0);
        $display("test collision and pins done");
        @(posedge ref_clk);
        slaveTest <= 1'b1;
        portCDirection <= 8'h18;
        cfg({1'b1, 1'b0, MODE_SLAVE_NOSEL});
        wr(8'h96);
        sbits(8'h5a, 8, q);
        chk(16'(q), 16'h0096);
        chk(16'(rdData), 16'h005a);
        chk(16'(wakes), 16'h1);
        sbits(8'hc3, 8, q);
        sbits(8'h0f, 8, q);
        sbits(8'hf0, 8, q);
        chk(16'(overflow), 16'h1);
        rdChk(8'h5a);
        tick(3);
        #1;
        chk(16'({bufferFull, rdData}), 16'h01c3);
        rdChk(8'hc3);
        rdChk(8'h0f);
        clr;
        $display("test slave done");
        cfg({1'b1, 1'b0, MODE_SLAVE_SEL});
        @(posedge ref_clk);
        tbSel <= 1'b1;
        sbits(8'hff, 8, q);
        chk(16'({portIntFlag, pinOut.sdoOe}), 16'h0);
        @(posedge ref_clk);
        tbSel <= 1'b0;
        sbits(8'h81, 4, q);
        @(posedge ref_clk);
        tbSel <= 1'b1;
        tick(6);
        tbSel <= 1'b0;
        tick(4);
        sbits(8'h24, 8, q);
        chk(16'(rdData), 16'h0024);
        $display("test slave select done");
        give_verdict;
    end
endmodule

`default_nettype wire
